// ==== rtl/usbe_pkg.sv ====
// Constants and types shared by the undercurrent stage event logic.
// Assumes a 25 MHz aclk and a 5 ms measurement strobe from the front end.
package usbe_pkg;
  localparam int CLK_NS    = 40;
  localparam int MS_NS     = 1000000;
  localparam int TICK_CYC  = MS_NS / CLK_NS;
  localparam int SAMPLE_MS = 5;
  localparam int PRE_MS    = 20;
  localparam int LAG200_MS = 200;
  localparam int AVG_N     = PRE_MS / SAMPLE_MS;
  localparam int LAG_N     = LAG200_MS / SAMPLE_MS;
  localparam logic [20:0] MAX_OP_MS = 21'h1b7740;
  localparam logic [23:0] HYST_PCT  = 24'h000067;
  localparam logic [23:0] FULL_PCT  = 24'h000064;
  localparam logic [3:0]  RING_N    = 4'hc;
  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_EVEN  = 8'h04;
  localparam logic [7:0] A_ISET  = 8'h08;
  localparam logic [7:0] A_DLY   = 8'h0c;
  localparam logic [7:0] A_RDLY  = 8'h10;
  localparam logic [7:0] A_STAT  = 8'h14;
  localparam logic [7:0] A_EXP   = 8'h18;
  localparam logic [7:0] A_NOW   = 8'h1c;
  localparam logic [7:0] A_CSTA  = 8'h20;
  localparam logic [7:0] A_CTRP  = 8'h24;
  localparam logic [7:0] A_CBLK  = 8'h28;
  localparam logic [7:0] A_RIDX  = 8'h2c;
  localparam logic [7:0] A_REC   = 8'h30;
  // Reset values
  localparam logic [6:0]  CTRL_RST = 7'h10;
  localparam logic [5:0]  EVEN_RST = 6'h3f;
  localparam logic [15:0] ISET_RST = 16'h0200;
  localparam logic [2:0]  LN_ON = 3'h1;
  localparam logic [2:0]  LN_BLK = 3'h2;
  localparam logic [2:0]  LN_TBLK = 3'h4;
  localparam logic [2:0]  LN_OFF = 3'h5;
  localparam logic [1:0]  RESP_OK = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TRIP, ST_BLOCK,
                            ST_REL} usbe_state_e;
endpackage

// ==== rtl/usbe_hist.sv ====
// Current history for pre-fault values: 20 ms mean ending 20 ms back
// and the sample 200 ms back. Push comes from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module usbe_hist
  import usbe_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        push,
  input  wire logic [15:0] sample,
  output logic      [15:0] avg20,
  output logic      [15:0] h200
);
  typedef struct packed {
    logic [63:0][15:0] mem;
    logic [5:0]        wp;
    logic [15:0]       avg;
    logic [15:0]       h;
  } usbe_hist_s;
  usbe_hist_s s, n;
  logic [17:0] sum;
  always_comb begin
    n = s;
    sum = 18'h0;
    if (push) begin
      n.mem[s.wp] = sample;
      n.wp = s.wp + 6'h1;
    end
    // At a strobe wp-1 is 5 ms old, so wp-AVG_N ends the window 20 ms back
    for (int k = AVG_N; k < 2 * AVG_N; k++) begin
      sum = sum + {2'h0, s.mem[s.wp - 6'(k)]};
    end
    n.avg = sum[17:2];
    n.h = s.mem[s.wp - 6'(LAG_N)];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= n;
  end
  assign avg20 = s.avg;
  assign h200 = s.h;
endmodule // usbe_hist
`default_nettype wire

// ==== rtl/usbe_ring.sv ====
// Ring of twelve fault records; read index 0 is the newest record.
// Writes come from the stage logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module usbe_ring
  import usbe_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         wr,
  input  wire logic [159:0] rec,
  input  wire logic [3:0]   rd_idx,
  output logic      [159:0] rd_rec,
  output logic      [3:0]   count
);
  typedef struct packed {
    logic [11:0][159:0] mem;
    logic [3:0]         head;
    logic [3:0]         cnt;
    logic [159:0]       rd;
  } usbe_ring_s;
  usbe_ring_s s, n;
  logic [4:0] slot;
  always_comb begin
    n = s;
    if (wr) begin
      // Full ring: head wraps onto the oldest entry and replaces it
      n.mem[s.head] = rec;
      n.head = (s.head == RING_N - 4'h1) ? 4'h0 : s.head + 4'h1;
      if (s.cnt != RING_N) n.cnt = s.cnt + 4'h1;
    end
    slot = {1'b0, s.head} + 5'(RING_N) - 5'h1 - {1'b0, rd_idx};
    if (slot >= 5'(RING_N)) slot = slot - 5'(RING_N);
    n.rd = (rd_idx < s.cnt) ? s.mem[slot[3:0]] : '0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= n;
  end
  assign rd_rec = s.rd;
  assign count = s.cnt;
endmodule // usbe_ring
`default_nettype wire

// ==== rtl/usbe_stage.sv ====
// Undercurrent stage: blocking, status, events, counters, fault records.
// Assumes front-end and blocking matrix logic on aclk; AXI4-Lite slave.
// Functional notes
// - Only definite-time delay for trip and release, no inverse curves.
// - Read-only condition: 0 normal, 1 started, 2 tripped, 3 blocked.
// - Read-only node behaviour: 1 on, 2 blocked, 3 test, 4 both, 5 off.
// - Read-only expected operating time, 0 to 1800 s in ms.
// - Blocking is sampled at each cycle start before pick-up evaluation.
// - Pick-up without blocking asserts start and runs the operate timer.
// - Pick-up under blocking asserts blocked only; no start, no timer.
// - Blocking during start drops start and runs the release timing.
// - Entering blocked raises a notification and a stamped block event.
// - With stage forcing enabled, a software switch drives blocking.
// - Separate on and off events for start, trip and blocked.
// - Per event selection of which events reach the event buffer.
// - Each event carries a timestamp and the captured minimum phase current.
// - Keep twelve newest fault records, one per cycle with any on event.
// - Record holds time, event, phases, currents, remaining time, group.
// - Timestamps resolve 1 ms; instant start and trip share a stamp.
// - Zero delay emits start and trip events in the same cycle.
// - Cumulative counters for start, trip and blocked occurrences.
// - Pre-fault value is a 20 ms mean ending 20 ms before the event.
// - Forced status overrides outputs only while forcing is enabled.
// - Pick-up releases at 103 percent of the common setting.
`timescale 1ns/1ns
`default_nettype none
module usbe_stage
  import usbe_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sample_valid,
  input  wire logic [15:0] phase_one_rms_current,
  input  wire logic [15:0] phase_two_rms_current,
  input  wire logic [15:0] phase_three_rms_current,
  input  wire logic        block_in,
  input  wire logic [2:0]  setting_group,
  output logic             start,
  output logic             trip,
  output logic             blocked,
  output logic             notify,
  output logic [5:0]       ev_strobe,
  output logic [31:0]      ev_stamp,
  output logic [15:0]      ev_current,
  output logic [15:0]      ev_prefault,
  output logic [2:0]       ev_phases
);
  typedef struct packed {
    usbe_state_e st;
    logic        pu;
    logic        blk;
    logic [2:0]  ph;
    logic [15:0] tick;
    logic [31:0] now;
    logic [20:0] op;
    logic [20:0] rel;
    logic [2:0]  outs;
    logic [5:0]  ev;
    logic        ntf;
    logic [31:0] stamp;
    logic [15:0] cur;
    logic [6:0]  ctrl;
    logic [5:0]  even;
    logic [15:0] iset;
    logic [20:0] dly;
    logic [20:0] rdly;
    logic [3:0]  ridx;
    logic [2:0][31:0] cnt;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } usbe_s;
  usbe_s s, n;

  logic [15:0]  cur_min;
  logic [15:0]  avg20;
  logic [15:0]  h200;
  logic [159:0] rd_rec;
  logic [3:0]   rcount;
  logic [159:0] rec;
  logic         rec_wr;
  logic [2:0]   below;
  logic [2:0]   above;
  logic         pu_n;
  logic         blk_n;
  logic         ms;
  logic [2:0]   nat;
  logic [2:0]   on_e;
  logic [2:0]   off_e;
  logic [1:0]   cond;
  logic [2:0]   ln;
  logic         force_en;
  logic [7:0]   wa;

  // Byte-lane merge of a write into an existing register value
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  // Phase is back over the release level (103 percent of the setting)
  function automatic logic over_rel(input logic [15:0] p,
                                    input logic [15:0] set);
    return ({8'h0, p} * FULL_PCT) >= ({8'h0, set} * HYST_PCT);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // History and fault-record ring
  usbe_hist u_hist (
    .aclk    (aclk),
    .aresetn (aresetn),
    .push    (sample_valid),
    .sample  (cur_min),
    .avg20   (avg20),
    .h200    (h200)
  );

  usbe_ring u_ring (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (rec_wr),
    .rec     (rec),
    .rd_idx  (s.ridx),
    .rd_rec  (rd_rec),
    .count   (rcount)
  );

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    n.ev = 6'h0;
    n.ntf = 1'b0;
    force_en = s.ctrl[0];
    ln = s.ctrl[6:4];
    // Minimum phase is the measured magnitude for an undercurrent stage
    cur_min = phase_one_rms_current;
    if (phase_two_rms_current < cur_min) cur_min = phase_two_rms_current;
    if (phase_three_rms_current < cur_min) cur_min = phase_three_rms_current;
    below[0] = phase_one_rms_current < s.iset;
    below[1] = phase_two_rms_current < s.iset;
    below[2] = phase_three_rms_current < s.iset;
    above[0] = over_rel(phase_one_rms_current, s.iset);
    above[1] = over_rel(phase_two_rms_current, s.iset);
    above[2] = over_rel(phase_three_rms_current, s.iset);

    // Millisecond time base for timers and stamps
    ms = (s.tick == 16'(TICK_CYCLES - 1));
    n.tick = ms ? 16'h0 : s.tick + 16'h1;
    if (ms) n.now = s.now + 32'h1;

    // Blocking and pick-up latched once per measurement cycle
    if (sample_valid) begin
      n.blk = force_en ? s.ctrl[1] : block_in;
      if (ln == LN_BLK || ln == LN_TBLK) n.blk = 1'b1;
      n.pu = s.pu ? ~&above : |below;
      n.ph = below;
    end
    pu_n = n.pu;
    blk_n = n.blk;

    // Definite-time operate and release timers only
    case (s.st)
      ST_IDLE: begin
        if (sample_valid && pu_n) begin
          n.op = s.dly;
          if (blk_n) n.st = ST_BLOCK;
          else if (s.dly == 21'h0) n.st = ST_TRIP;
          else n.st = ST_START;
        end
      end
      ST_START: begin
        if (sample_valid && (blk_n || !pu_n)) begin
          n.st = ST_REL;
          n.rel = s.rdly;
        end else if (ms) begin
          if (s.op <= 21'h1) n.st = ST_TRIP;
          n.op = (s.op == 21'h0) ? 21'h0 : s.op - 21'h1;
        end
      end
      ST_REL: begin
        if (sample_valid && pu_n && !blk_n) n.st = ST_START;
        else if (s.rel == 21'h0) n.st = ST_IDLE;
        else if (ms) begin
          n.rel = s.rel - 21'h1;
          if (s.rel == 21'h1) n.st = ST_IDLE;
        end
      end
      ST_TRIP: begin
        if (sample_valid && (blk_n || !pu_n)) n.st = ST_IDLE;
      end
      ST_BLOCK: begin
        if (sample_valid && (!blk_n || !pu_n)) n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase
    if (ln == LN_OFF) n.st = ST_IDLE;
    if (n.st == ST_IDLE) n.op = 21'h0;

    // Output bits are {blocked, trip, start}
    nat = {n.st == ST_BLOCK, n.st == ST_TRIP,
           n.st == ST_START || n.st == ST_TRIP};
    n.outs = nat;
    if (force_en) begin
      case (s.ctrl[3:2])
        2'h1: n.outs = 3'h1;
        2'h2: n.outs = 3'h3;
        2'h3: n.outs = 3'h4;
        default: n.outs = nat;
      endcase
    end

    // Events, counters and records from output transitions
    on_e = n.outs & ~s.outs;
    off_e = s.outs & ~n.outs;
    n.ev = {off_e, on_e} & s.even;
    n.ntf = on_e[2];
    if (|{on_e, off_e}) begin
      n.stamp = n.now;
      n.cur = cur_min;
    end
    for (int i = 0; i < 3; i++) begin
      if (on_e[i]) n.cnt[i] = s.cnt[i] + 32'h1;
    end
    rec_wr = |on_e;
    rec = {11'h0, n.op, 16'h0, h200, avg20, cur_min, 23'h0,
           setting_group, below,
           on_e[1] ? 3'h2 : on_e[2] ? 3'h3 : 3'h1, n.now};

    cond = s.outs[2] ? 2'h3 : s.outs[1] ? 2'h2 : s.outs[0] ? 2'h1 : 2'h0;

    //////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
    wa = s.awaddr;
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OK;
      case (wa)
        A_CTRL: n.ctrl = 7'(wmerge({25'h0, s.ctrl}, s.wdata, s.wstrb));
        A_EVEN: n.even = 6'(wmerge({26'h0, s.even}, s.wdata, s.wstrb));
        A_ISET: n.iset = 16'(wmerge({16'h0, s.iset}, s.wdata, s.wstrb));
        A_DLY: begin
          n.dly = 21'(wmerge({11'h0, s.dly}, s.wdata, s.wstrb));
          if (n.dly > MAX_OP_MS) n.dly = MAX_OP_MS;
        end
        A_RDLY: begin
          n.rdly = 21'(wmerge({11'h0, s.rdly}, s.wdata, s.wstrb));
          if (n.rdly > MAX_OP_MS) n.rdly = MAX_OP_MS;
        end
        // Clearing a counter while it counts leaves the new event
        A_CSTA: n.cnt[0] = {31'h0, on_e[0]};
        A_CTRP: n.cnt[1] = {31'h0, on_e[1]};
        A_CBLK: n.cnt[2] = {31'h0, on_e[2]};
        A_RIDX: n.ridx = 4'(wmerge({28'h0, s.ridx}, s.wdata, s.wstrb));
        default: n.bresp = RESP_ERR;
      endcase
      if (wa == A_CTRL && n.ctrl[6:4] == 3'h0) n.ctrl[6:4] = LN_ON;
      if (wa == A_CTRL && n.ctrl[6:4] > LN_OFF) n.ctrl[6:4] = s.ctrl[6:4];
    end

    // AXI4-Lite read: one cycle from address to data
    if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OK;
      case (s_axi_araddr)
        A_CTRL: n.rdata = {25'h0, s.ctrl};
        A_EVEN: n.rdata = {26'h0, s.even};
        A_ISET: n.rdata = {16'h0, s.iset};
        A_DLY:  n.rdata = {11'h0, s.dly};
        A_RDLY: n.rdata = {11'h0, s.rdly};
        A_STAT: n.rdata = {24'h0, s.outs, ln, cond};
        A_EXP:  n.rdata = {11'h0, s.op};
        A_NOW:  n.rdata = s.now;
        A_CSTA: n.rdata = s.cnt[0];
        A_CTRP: n.rdata = s.cnt[1];
        A_CBLK: n.rdata = s.cnt[2];
        A_RIDX: n.rdata = {24'h0, rcount, s.ridx};
        default: begin
          if (s_axi_araddr >= A_REC && s_axi_araddr < A_REC + 8'h14) begin
            n.rdata = rd_rec[32 * ((s_axi_araddr - A_REC) >> 2) +: 32];
          end else begin
            n.rdata = 32'h0;
            n.rresp = RESP_ERR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.even <= EVEN_RST;
      s.iset <= ISET_RST;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign start         = s.outs[0];
  assign trip          = s.outs[1];
  assign blocked       = s.outs[2];
  assign notify        = s.ntf;
  assign ev_strobe     = s.ev;
  assign ev_stamp      = s.stamp;
  assign ev_current    = s.cur;
  assign ev_prefault   = avg20;
  assign ev_phases     = s.ph;
endmodule // usbe_stage
`default_nettype wire

// ==== testbench/usbe_front_model.sv ====
// Model of the measurement front end and the blocking matrix.
// Assumes the bench sets cur, off and blk on aclk edges.
`timescale 1ns/1ns
`default_nettype none
module usbe_front_model #(
  parameter int PERIOD = 20
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] cur,
  input  wire logic [15:0] off,
  input  wire logic        blk,
  output logic             sample_valid,
  output logic [15:0]      p1,
  output logic [15:0]      p2,
  output logic [15:0]      p3,
  output logic             block_in
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt          <= 0;
      sample_valid <= 1'b0;
    end else begin
      cnt          <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sample_valid <= (cnt == PERIOD - 1);
    end
  end
  // Values are only valid on the strobe; show junk in between so that
  // a design sampling at the wrong time sees the wrong level
  always_comb begin
    p1       = sample_valid ? cur : ~cur;
    p2       = sample_valid ? cur + off : ~cur;
    p3       = sample_valid ? cur + (off >> 1) : ~cur;
    block_in = sample_valid ? blk : ~blk;
  end
endmodule // usbe_front_model
`default_nettype wire

// ==== testbench/usbe_stage_asserts.sv ====
// Port checker for the undercurrent stage.
// Assumes it is bound onto usbe_stage; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module usbe_stage_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sample_valid,
  input wire logic        block_in,
  input wire logic        start,
  input wire logic        trip,
  input wire logic        blocked,
  input wire logic        notify,
  input wire logic [5:0]  ev_strobe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  AST_START_RISE: assert property (
    $rose(start) |-> $past(sample_valid) && !$past(block_in))
    else $error("start rose without an unblocked sample");
  AST_BLK_RISE: assert property (
    $rose(blocked) |-> $past(sample_valid) && $past(block_in))
    else $error("blocked rose without a blocked sample");
  AST_BLK_NO_START: assert property (blocked |-> !start)
    else $error("start and blocked high together");
  AST_NOTIFY: assert property (1'b1 |-> notify == $rose(blocked))
    else $error("notify not tied to blocked rising");
  AST_EV_START_ON: assert property (ev_strobe[0] |-> $rose(start))
    else $error("start on event without start rising");
  AST_EV_START_OFF: assert property (ev_strobe[3] |-> $fell(start))
    else $error("start off event without start falling");
  AST_EV_BLK_ON: assert property (ev_strobe[2] |-> $rose(blocked))
    else $error("block on event without blocked rising");
  AST_TRIP_START: assert property ($rose(trip) |-> start)
    else $error("trip rose without start");
  AST_RHOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before rready");
  AST_ARREADY: assert property (1'b1 |-> s_axi_arready == !s_axi_rvalid)
    else $error("arready not the inverse of rvalid");
endmodule // usbe_stage_asserts
`default_nettype wire
bind usbe_stage usbe_stage_asserts chk_u (.*);

// ==== testbench/usbe_stage_tb.sv ====
// Self-checking bench for the undercurrent stage.
// Assumes the front model on the measurement side and a 1 ms of 4 cycles.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
`define WV(s, v, l) begin for (c = 0; c < (l) && (s) !== (v); c++) \
  @(posedge aclk); if ((s) !== (v)) begin n_fail++; \
  $display("BAD wait exp %0h got %0h", v, s); conclude(); end end
module usbe_stage_tb;
  import usbe_pkg::*;
  logic aclk = 0, aresetn = 0, sample_valid, block_in, start, trip;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, ev_stamp;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, blocked, notify, blk = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] phase_one_rms_current, phase_two_rms_current, ev_current;
  logic [15:0] ev_prefault;
  logic [15:0] phase_three_rms_current, cur = 16'h0300, off = 0;
  logic [2:0] setting_group = 0, ev_phases;
  logic [5:0] ev_strobe;
  int n_fail = 0, tests_run = 0, seed = 27525, c, nfy = 0, both = 0;
  int evc[6] = '{default: 0}, cyc = 0;
  int m_ev[6] = '{default: 0};
  ////////////////////////////////////////////////////////////////////////////
  usbe_stage #(.TICK_CYCLES(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid,
    .phase_one_rms_current, .phase_two_rms_current, .phase_three_rms_current,
    .block_in, .setting_group, .start, .trip, .blocked, .notify, .ev_strobe,
    .ev_stamp, .ev_current, .ev_prefault, .ev_phases);
  usbe_front_model #(.PERIOD(20)) front_u (.aclk, .aresetn, .cur, .off,
    .blk, .sample_valid, .p1(phase_one_rms_current),
    .p2(phase_two_rms_current), .p3(phase_three_rms_current), .block_in);
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    if (aresetn) begin
      // cyc counts edges out of reset; the stamp shows whole ms of them
      if (|ev_strobe) `CHK("ev_stamp", 32'(cyc / 4), ev_stamp)
      cyc++;
      for (int i = 0; i < 6; i++) evc[i] += int'(ev_strobe[i] === 1'b1);
      nfy += int'(notify === 1'b1);
      both += int'(ev_strobe[0] === 1'b1 && ev_strobe[1] === 1'b1);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (k == 200) begin
      n_fail++;
      $display("BAD bvalid exp 1 got 0");
      conclude();
    end
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k == 200) begin
      n_fail++;
      $display("BAD rvalid exp 1 got 0");
      conclude();
    end
  endtask
  // Two edges let the event monitor count the last strobe first
  task chkev;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 6; i++) `CHK("event_count", m_ev[i], evc[i])
  endtask
  task pulse_on(input logic [15:0] lvl);
    off <= 16'($random(seed)) & 16'h00ff;
    cur <= lvl;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    setting_group <= 3'($random(seed));
    axr(A_STAT, rd, rs);
    `CHK("status", {24'h0, 3'h0, LN_ON, 2'h0}, rd[31:0])
    axr(A_EVEN, rd, rs);
    `CHK("ev_enable", {26'h0, EVEN_RST}, rd)
    axr(8'h44, rd, rs);
    `CHK("rresp", RESP_ERR, rs)
    axw(8'h44, 32'h0, RESP_ERR);
    axw(A_DLY, 32'h0000000a, RESP_OK);
    axw(A_RDLY, 32'h0, RESP_OK);
    pulse_on(16'h0100);
    `WV(start, 1'b1, 50)
    `WV(trip, 1'b1, 80)
    `CHK("trip_delay", 1'b1, c >= 36 && c <= 44)
    m_ev[0]++; m_ev[1]++;
    cur <= 16'h020f;
    repeat (50) @(posedge aclk);
    `CHK("hyst_hold", 1'b1, start)
    cur <= 16'h0210;
    `WV(start, 1'b0, 25)
    `CHK("trip_off", 1'b0, trip)
    m_ev[3]++; m_ev[4]++;
    chkev();
    axw(A_DLY, 32'h0, RESP_OK);
    axw(A_CSTA, 32'h0, RESP_OK);
    axw(A_CTRP, 32'h0, RESP_OK);
    pulse_on(16'h0100);
    `WV(trip, 1'b1, 50)
    `CHK("ev_current", 16'h0100, ev_current)
    cur <= 16'h0300;
    `WV(start, 1'b0, 25)
    m_ev[0]++; m_ev[1]++; m_ev[3]++; m_ev[4]++;
    chkev();
    `CHK("same_cycle", 1, both)
    axw(A_EVEN, 32'h0000003e, RESP_OK);
    pulse_on(16'h0100);
    `WV(trip, 1'b1, 50)
    cur <= 16'h0300;
    `WV(start, 1'b0, 25)
    m_ev[1]++; m_ev[3]++; m_ev[4]++;
    chkev();
    axw(A_EVEN, 32'h0000003f, RESP_OK);
    axr(A_CSTA, rd, rs);
    `CHK("cnt_start", 32'h2, rd)
    axr(A_CTRP, rd, rs);
    `CHK("cnt_trip", 32'h2, rd)
    axw(A_CBLK, 32'h0, RESP_OK);
    blk <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      pulse_on(16'h0100);
      `WV(blocked, 1'b1, 50)
      `CHK("no_start", 1'b0, start)
      `CHK("ev_phases", 3'h7, ev_phases)
      if (i == 0) begin
        axr(A_STAT, rd, rs);
        `CHK("cond_blk", 2'h3, rd[1:0])
      end
      cur <= 16'h0300;
      `WV(blocked, 1'b0, 50)
      m_ev[2]++; m_ev[5]++;
    end
    chkev();
    `CHK("notify", 9, nfy)
    axr(A_CBLK, rd, rs);
    `CHK("cnt_block", 32'h9, rd)
    axw(A_RIDX, 32'h0, RESP_OK);
    axr(A_RIDX, rd, rs);
    `CHK("rec_count", RING_N, rd[7:4])
    axr(A_REC + 8'h04, rd, rs);
    `CHK("rec_event", 3'h3, rd[2:0])
    `CHK("rec_group", setting_group, rd[8:6])
    `CHK("rec_phases", 3'h7, rd[5:3])
    blk <= 1'b0;
    axw(A_DLY, 32'h00000064, RESP_OK);
    pulse_on(16'h0100);
    `WV(start, 1'b1, 50)
    blk <= 1'b1;
    `WV(start, 1'b0, 25)
    // Outlast the 100 ms delay so that a missed block would show as a trip
    repeat (450) @(posedge aclk);
    `CHK("trip_none", 1'b0, trip)
    `CHK("prefault", 16'h0100, ev_prefault)
    conclude();
  end
endmodule // usbe_stage_tb
`default_nettype wire
